// [lmp_defs.svh]
// Purpose: Constants for the lamp driver serial slave and its registers.
// Assumes: Included by bare name; definitions only.
// Notes: Offsets are register indexes as seen through the pointer byte.
`ifndef LMP_DEFS_SVH
`define LMP_DEFS_SVH

// ==========================================
// Register map
`define LMP_REG_ID 4'h0
`define LMP_REG_AUX 4'h5
`define LMP_REG_CH1 4'h4
`define LMP_REG_CH2 4'h7
`define LMP_REG_CH3 4'h8
`define LMP_REG_CH4 4'h9
`define LMP_REG_TOP 8'h0b
`define LMP_REG_RESET 8'h00

// ==========================================
// Fields
`define LMP_RAMP_MSB 7
`define LMP_RAMP_LSB 5
`define LMP_AMP_MSB 4
`define LMP_AMP_LSB 0
`define LMP_AUX_SEL_MSB 5
`define LMP_AUX_SEL_LSB 4
`define LMP_ADDR_FIXED 5'h1e

// ==========================================
// Timing
`define LMP_CLK_NS 20
`define LMP_TENTH_MS_NS 100000
`define LMP_AMP_STEPS 31
`define LMP_AUX_HALF_MAX 8

`endif

// [lmp_pkg.sv]
// Purpose: Types shared by the lamp driver slave.
// Assumes: Constants live in lmp_defs.svh.
// Notes: None.
package lmp_pkg;
    typedef logic [7:0] lmp_byte_t;
    typedef enum logic [2:0] {
        lmp_idle,
        lmp_addr,
        lmp_ptr,
        lmp_wdata,
        lmp_rdata,
        lmp_ignore
    } lmp_state_e;
endpackage

// [lmp_sync.sv]
// Purpose: Two-stage synchroniser for asynchronous pins.
// Assumes: One clock, synchronous reset.
// Notes: First stage is read only by the second.
`timescale 1ns/100ps
module lmp_sync #(
    parameter int W = 1,
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= {W{RST_VAL}};
            sync_out <= {W{RST_VAL}};
        end else begin
            meta <= pin_in;
            sync_out <= meta;
        end
    end
endmodule // lmp_sync

// [lmp_buf.sv]
// Purpose: Two-entry valid/ready buffer for received register writes.
// Assumes: Depth is a power of two.
// Notes: Full drops in_ready so the slave can refuse a byte.
`timescale 1ns/100ps
module lmp_buf #(
    parameter int W = 12,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("lmp_buf depth must be a power of two of at least 2");
        end
    endgenerate

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // lmp_buf

// [lmp_slave.sv]
// Purpose: Two-wire serial slave, register file and lamp control for four lamps.
// Assumes: clk at 50 MHz, bus clock at most 400kHz, all pins asynchronous.
// Notes: Outputs are registered; data line is open-drain through sda_oe.
`include "lmp_defs.svh"
`timescale 1ns/100ps
module lmp_slave #(
    parameter int unsigned CYC_PER_TENTH_MS = `LMP_TENTH_MS_NS / `LMP_CLK_NS,
    parameter lmp_pkg::lmp_byte_t DEV_ID = 8'h5a
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Address select pins
    input wire logic addr_select_pin_high,
    input wire logic addr_select_pin_low,
    // Auxiliary input and divided output
    input wire logic aux_in,
    output logic aux_div_out,
    // Lamp levels, channel 4 in the top five bits
    output logic [3:0][4:0] lamp_level,
    output logic [3:0] ramp_busy
);
    import lmp_pkg::*;

    // DEV_ID default is an arbitrary value.
    generate
        if (CYC_PER_TENTH_MS < 1) begin : g_bad_tenth
            $error("CYC_PER_TENTH_MS must be at least 1");
        end
    endgenerate

    // ==========================================
    // Functions
    function automatic logic [31:0] step_cycles(input logic [2:0] code);
        logic [31:0] tenths;
        tenths = 32'h0;
        case (code)
            3'h1: tenths = 32'd625;
            3'h2: tenths = 32'd1250;
            3'h3: tenths = 32'd2500;
            3'h4: tenths = 32'd5000;
            3'h5: tenths = 32'd7500;
            3'h6: tenths = 32'd10000;
            3'h7: tenths = 32'd20000;
            default: tenths = 32'h0;
        endcase
        return 32'((64'(tenths) * 64'(CYC_PER_TENTH_MS)) / 64'(`LMP_AMP_STEPS));
    endfunction

    function automatic logic [3:0] clamp_ptr(input logic [7:0] p);
        return (p > `LMP_REG_TOP) ? 4'(`LMP_REG_TOP) : p[3:0];
    endfunction

    // ==========================================
    // Pin synchronisers
    logic [4:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic aux_s;
    logic sel_hi_s;
    logic sel_lo_s;
    logic scl_d;
    logic sda_d;
    logic aux_d;

    lmp_sync #(.W(5), .RST_VAL(1'b1)) i_lmp_sync (
        .clk(clk),
        .rst(rst),
        .pin_in({scl_in, sda_in, aux_in, addr_select_pin_high, addr_select_pin_low}),
        .sync_out(pins_s)
    );

    assign {scl_s, sda_s, aux_s, sel_hi_s, sel_lo_s} = pins_s;

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            aux_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            aux_d <= aux_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det = scl_s && scl_d && !sda_d && sda_s;

    // ==========================================
    // Bus state
    lmp_state_e state;
    logic [3:0] bit_cnt;
    logic ack_phase;
    logic rep_start;
    logic master_nack;
    logic start_seen;
    lmp_byte_t rx_shift;
    lmp_byte_t tx_byte;
    logic [3:0] ptr;
    logic [7:0] regs [12];
    logic addr_match;
    logic is_read;
    logic fill_ready;
    logic fill_valid;
    logic [11:0] drain_data;
    logic drain_valid;
    logic drain_ready;
    logic rd_load;
    logic [3:0] rd_ptr_now;

    assign addr_match = (rx_shift[7:1] == {`LMP_ADDR_FIXED, sel_hi_s, sel_lo_s});
    assign is_read = rx_shift[0];
    // Data byte complete in write state, offered to buffer
    assign fill_valid = scl_fall && !ack_phase && (bit_cnt == 4'd8)
        && (state == lmp_wdata);
    // Byte to send is fetched when a read byte starts
    assign rd_load = scl_fall && ack_phase && !master_nack
        && ((state == lmp_rdata) || ((state == lmp_addr) && addr_match && is_read));
    // fresh START read starts at register 0
    assign rd_ptr_now = ((state == lmp_addr) && !rep_start) ? 4'h0 : ptr;

    // Receive shift and bit count on rising clock
    always_ff @(posedge clk) begin
        if (rst) begin
            bit_cnt <= 4'h0;
            rx_shift <= 8'h00;
        end else if (start_det || stop_det) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise && !ack_phase && bit_cnt != 4'd8) begin
            rx_shift <= {rx_shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
        end else if (scl_fall && ack_phase) begin
            bit_cnt <= 4'h0;
        end
    end

    // Master acknowledge sampled in the ninth pulse of reads
    always_ff @(posedge clk) begin
        if (rst || start_det) begin
            master_nack <= 1'b0;
        end else if (scl_rise && ack_phase && state == lmp_rdata) begin
            master_nack <= sda_s;
        end
    end

    // Frame state
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= lmp_idle;
            ack_phase <= 1'b0;
            rep_start <= 1'b0;
            start_seen <= 1'b0;
        // repeated START goes back to address
        end else if (start_det) begin
            rep_start <= (state != lmp_idle);
            state <= lmp_addr;
            ack_phase <= 1'b0;
            start_seen <= 1'b1;
        // STOP at any bit, not in the START high phase
        end else if (stop_det && !start_seen) begin
            state <= lmp_idle;
            ack_phase <= 1'b0;
        end else if (scl_fall) begin
            start_seen <= 1'b0;
            if (!ack_phase && bit_cnt == 4'd8) begin
                ack_phase <= 1'b1;
                if (state == lmp_addr && !addr_match) begin
                    state <= lmp_ignore;
                    ack_phase <= 1'b0;
                end
            end else if (ack_phase) begin
                ack_phase <= 1'b0;
                case (state)
                    lmp_addr: state <= is_read ? lmp_rdata : lmp_ptr;
                    lmp_ptr: state <= lmp_wdata;
                    lmp_wdata: state <= lmp_wdata;
                    lmp_rdata: state <= master_nack ? lmp_ignore : lmp_rdata;
                    default: state <= lmp_ignore;
                endcase
            end
        end
    end

    // Register pointer
    always_ff @(posedge clk) begin
        if (rst) begin
            ptr <= 4'h0;
        end else if (scl_fall && !ack_phase && bit_cnt == 4'd8
                && state == lmp_ptr) begin
            ptr <= clamp_ptr(rx_shift);
        end else if (fill_valid && fill_ready) begin
            ptr <= (ptr == 4'(`LMP_REG_TOP)) ? ptr : ptr + 4'h1;
        end else if (rd_load) begin
            ptr <= (rd_ptr_now == 4'(`LMP_REG_TOP)) ? rd_ptr_now : rd_ptr_now + 4'h1;
        end
    end

    // Byte to transmit
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_byte <= 8'h00;
        end else if (rd_load) begin
            // preset pointer kept across repeated START
            tx_byte <= (rd_ptr_now == `LMP_REG_ID) ? DEV_ID : regs[rd_ptr_now];
        end
    end

    // Data line drive
    always_ff @(posedge clk) begin
        if (rst) begin
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            if (start_det || stop_det || state == lmp_idle || state == lmp_ignore) begin
                sda_oe <= 1'b0;
            end else if (scl_fall) begin
                if (!ack_phase && bit_cnt == 4'd8) begin
                    // ack every good byte in write mode
                    case (state)
                        lmp_addr: sda_oe <= addr_match;
                        lmp_ptr: sda_oe <= 1'b1;
                        lmp_wdata: sda_oe <= fill_ready;
                        default: sda_oe <= 1'b0;
                    endcase
                end else if (rd_load) begin
                    // first bit set up while clock low
                    sda_oe <= !((rd_ptr_now == `LMP_REG_ID) ? DEV_ID[7]
                        : regs[rd_ptr_now][7]);
                end else if (ack_phase) begin
                    sda_oe <= 1'b0;
                end else if (state == lmp_rdata && bit_cnt != 4'd0) begin
                    // one bit per clock, changed only while low
                    sda_oe <= !tx_byte[3'(4'd7 - bit_cnt)];
                end
            end
        end
    end

    // ==========================================
    // Write buffer and register file
    // Drain stalls in the fetch cycle so a read sees a settled array
    assign drain_ready = !rd_load;

    lmp_buf #(.W(12), .DEPTH(2)) i_lmp_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(fill_valid),
        .in_ready(fill_ready),
        .in_data({ptr, rx_shift}),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_data)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 12; i++) begin
                regs[i] <= `LMP_REG_RESET;
            end
        end else if (drain_valid && drain_ready) begin
            regs[drain_data[11:8]] <= drain_data[7:0];
        end
    end

    // ==========================================
    // Aux divider
    logic [1:0] aux_sel;
    logic [2:0] aux_cnt;
    logic [3:0] aux_half;

    assign aux_sel = regs[`LMP_REG_AUX][`LMP_AUX_SEL_MSB:`LMP_AUX_SEL_LSB];
    // half period of 8, 4, 2, 1 input edges
    assign aux_half = 4'(`LMP_AUX_HALF_MAX) >> aux_sel;

    always_ff @(posedge clk) begin
        if (rst) begin
            aux_cnt <= 3'h0;
            aux_div_out <= 1'b0;
        end else if (aux_s && !aux_d) begin
            if ({1'b0, aux_cnt} >= aux_half - 4'h1) begin
                aux_cnt <= 3'h0;
                aux_div_out <= !aux_div_out;
            end else begin
                aux_cnt <= aux_cnt + 3'h1;
            end
        end
    end

    // ==========================================
    // Lamp ramps
    logic [3:0][3:0] ch_idx;
    assign ch_idx = {`LMP_REG_CH4, `LMP_REG_CH3, `LMP_REG_CH2, `LMP_REG_CH1};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ch
            logic [7:0] cfg;
            logic [4:0] target;
            logic [31:0] step;
            logic [31:0] timer;

            assign cfg = regs[ch_idx[g]];
            assign target = cfg[`LMP_AMP_MSB:`LMP_AMP_LSB];
            // ramp time spread over the full amplitude range
            assign step = step_cycles(cfg[`LMP_RAMP_MSB:`LMP_RAMP_LSB]);

            always_ff @(posedge clk) begin
                if (rst) begin
                    lamp_level[g] <= 5'h00;
                    ramp_busy[g] <= 1'b0;
                    timer <= 32'h0;
                end else if (lamp_level[g] == target) begin
                    ramp_busy[g] <= 1'b0;
                    timer <= 32'h0;
                end else if (timer + 32'h1 >= step) begin
                    // linear level, one code per step
                    lamp_level[g] <= (lamp_level[g] < target)
                        ? lamp_level[g] + 5'h01 : lamp_level[g] - 5'h01;
                    ramp_busy[g] <= 1'b1;
                    timer <= 32'h0;
                end else begin
                    ramp_busy[g] <= 1'b1;
                    timer <= timer + 32'h1;
                end
            end
        end
    endgenerate

    // three-cycle sampling lag is far below a 400kHz half period
endmodule // lmp_slave

// [lmp_slave_props.sv]
// Purpose: Port checker for the lamp driver serial slave.
// Assumes: Bus pins change on clk edges, eight clk per bit.
// Notes: Bound to every lmp_slave instance.
`timescale 1ns/100ps
module lmp_slave_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Address select pins
    input wire logic addr_select_pin_high,
    input wire logic addr_select_pin_low,
    // Aux and lamps
    input wire logic aux_in,
    input wire logic aux_div_out,
    input wire logic [3:0][4:0] lamp_level,
    input wire logic [3:0] ramp_busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ==========================================
    // Bit tracker
    logic scl_q, sda_q, first, start_ev, rise_ev, hit;
    logic [3:0] bit_n;
    logic [7:0] shift;
    assign start_ev = scl_in && scl_q && sda_q && !sda_in;
    assign rise_ev = scl_in && !scl_q;
    assign hit = (shift[7:1] == {5'h1e, addr_select_pin_high, addr_select_pin_low});
    always_ff @(posedge clk) begin
        scl_q <= scl_in;
        sda_q <= sda_in;
    end
    always_ff @(posedge clk) begin
        if (rst || start_ev) begin
            bit_n <= 4'h0;
            first <= 1'b1;
        end else if (rise_ev) begin
            bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
            if (bit_n == 4'h8) begin
                first <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rise_ev) begin
            shift <= {shift[6:0], sda_in};
        end
    end
    sequence stop_s;
        scl_in && scl_q && !sda_q && sda_in;
    endsequence
    sequence addr_end_s;
        first && (bit_n == 4'h8);
    endsequence
    // ==========================================
    // Assertions
    AST_NEVER_HIGH:
        assert property (!sda_out) else $error("data line driven high");
    AST_RESET_QUIET:
        assert property ($past(rst) |-> !sda_oe && !aux_div_out && lamp_level == '0)
        else $error("outputs not cleared by reset");
    AST_STOP_RELEASE:
        assert property (stop_s |=> !sda_oe [*8]) else $error("data held after stop");
    AST_OE_STABLE:
        assert property (scl_in && scl_q |-> $stable(sda_oe))
        else $error("data moved while clock high");
    AST_ACK_HOLD:
        assert property (rise_ev && sda_oe |-> sda_oe [*3]) else $error("pull dropped early");
    AST_ADDR_ACK:
        assert property (addr_end_s ##0 (rise_ev && hit) |-> sda_oe)
        else $error("own address not acknowledged");
    AST_ADDR_MISS:
        assert property (addr_end_s ##0 !hit |-> !sda_oe)
        else $error("foreign address acknowledged");
    AST_AUX_QUIET:
        assert property (!aux_in [*8] |=> $stable(aux_div_out))
        else $error("divider moved without aux edge");
    for (genvar c = 0; c < 4; c++) begin : g_ch
        AST_LEVEL_STEP:
            assert property (lamp_level[c] == $past(lamp_level[c])
                || lamp_level[c] == $past(lamp_level[c]) + 5'h1
                || lamp_level[c] + 5'h1 == $past(lamp_level[c]))
            else $error("lamp level jumped");
    end
endmodule // lmp_slave_props

bind lmp_slave lmp_slave_props i_lmp_slave_props (.clk(clk), .rst(rst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_pin_high(addr_select_pin_high), .addr_select_pin_low(addr_select_pin_low),
    .aux_in(aux_in), .aux_div_out(aux_div_out), .lamp_level(lamp_level),
    .ramp_busy(ramp_busy));

// [lmp_master_model.sv]
// Purpose: Two-wire bus master model.
// Assumes: Open-drain data with pull-up in the bench.
// Notes: 160 ns bit: 5 clk low, 3 clk high; clock idles high.
`timescale 1ns/100ps
module lmp_master_model (
    // Clock
    input wire logic clk,
    // Bus
    output logic scl,
    output logic sda_pull,
    input wire logic sda_line
);
    // master owns the clock, idle high
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic start_cond();
        sda_pull <= 1'b0;
        wt(3);
        scl <= 1'b1;
        wt(4);
        sda_pull <= 1'b1;
        wt(4);
        scl <= 1'b0;
        wt(2);
    endtask
    // data moves only while clock low
    task automatic bit_xfer(input logic b, output logic r);
        sda_pull <= ~b;
        wt(3);
        scl <= 1'b1;
        wt(2);
        r = sda_line;
        wt(1);
        scl <= 1'b0;
        wt(2);
    endtask
    task automatic byte_xfer(input logic [7:0] d, input logic ack_in,
                             output logic [7:0] q, output logic ack_out);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
            q[i] = r;
        end
        bit_xfer(ack_in, ack_out);
    endtask
    // stop in its own high phase
    task automatic stop_cond();
        sda_pull <= 1'b1;
        wt(3);
        scl <= 1'b1;
        wt(4);
        sda_pull <= 1'b0;
        wt(6);
    endtask
endmodule // lmp_master_model

// [tb_lmp_slave.sv]
// Purpose: Self-checking bench for the lamp driver serial slave.
// Assumes: Master model drives the bus; pins tied high by default.
// Notes: Ramp counts shortened through CYC_PER_TENTH_MS.
`timescale 1ns/100ps
module tb_lmp_slave;
    import lmp_pkg::*;
    // Arbitrary identity value
    localparam lmp_byte_t DEV_ID = 8'h3c;
    localparam lmp_byte_t AW = 8'hf6;
    localparam lmp_byte_t AR = 8'hf7;
    logic clk, rst, pin_hi, pin_lo, aux_in, scl, pull, sda_oe, sda_out, aux_div_out, t;
    logic sda_line;
    logic [3:0][4:0] lamp_level;
    logic [3:0] ramp_busy;
    int error_cnt = 0;
    int tests_run = 0;
    int n;
    // Pull-up on data
    assign sda_line = (sda_oe ? sda_out : 1'b1) & ~pull;
    lmp_slave #(.CYC_PER_TENTH_MS(1), .DEV_ID(DEV_ID)) i_lmp_slave (.clk(clk), .rst(rst),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_select_pin_high(pin_hi), .addr_select_pin_low(pin_lo), .aux_in(aux_in),
        .aux_div_out(aux_div_out), .lamp_level(lamp_level), .ramp_busy(ramp_busy));
    lmp_master_model i_lmp_master_model (.clk(clk), .scl(scl), .sda_pull(pull),
        .sda_line(sda_line));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========================================
    // Tasks
    task automatic final_report();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check8(input string name, input lmp_byte_t exp, input lmp_byte_t got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check1(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic send(input lmp_byte_t d, input logic exp_ack, input string name);
        lmp_byte_t q;
        logic a;
        i_lmp_master_model.byte_xfer(d, 1'b1, q, a);
        check1(name, exp_ack, a);
    endtask
    task automatic recv(input lmp_byte_t exp, input logic last, input string name);
        lmp_byte_t q;
        logic a;
        i_lmp_master_model.byte_xfer(8'hff, last, q, a);
        check8(name, exp, q);
    endtask
    task automatic wr(input lmp_byte_t ptr, input lmp_byte_t d[$]);
        i_lmp_master_model.start_cond();
        send(AW, 1'b0, "addr ack");
        send(ptr, 1'b0, "ptr ack");
        foreach (d[i]) send(d[i], 1'b0, "data ack");
        i_lmp_master_model.stop_cond();
    endtask
    task automatic aux_pulse(output logic tog);
        logic b;
        b = aux_div_out;
        aux_in <= 1'b1;
        repeat (4) @(posedge clk);
        aux_in <= 1'b0;
        repeat (4) @(posedge clk);
        tog = (aux_div_out !== b);
    endtask
    // ==========================================
    // Sequence
    initial begin
        rst = 1'b1;
        pin_hi = 1'b1;
        pin_lo = 1'b1;
        aux_in = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check1("idle release", 1'b0, sda_oe);
        for (int p = 0; p < 4; p++) begin
            {pin_hi, pin_lo} <= 2'(p);
            i_lmp_master_model.wt(4);
            i_lmp_master_model.start_cond();
            send({5'h1e, 2'(p), 1'b0}, 1'b0, "pin addr ack");
            i_lmp_master_model.stop_cond();
        end
        i_lmp_master_model.start_cond();
        send(8'hf2, 1'b1, "miss ack");
        send(8'h09, 1'b1, "miss byte");
        i_lmp_master_model.stop_cond();
        // Frame cut after three bits must leave the slave idle
        i_lmp_master_model.start_cond();
        for (int b = 0; b < 3; b++) i_lmp_master_model.bit_xfer(1'b1, t);
        i_lmp_master_model.stop_cond();
        check1("early stop release", 1'b0, sda_oe);
        wr(8'h09, '{8'h03, 8'h11, 8'h22, 8'h33});
        i_lmp_master_model.start_cond();
        send(AW, 1'b0, "addr ack");
        send(8'h09, 1'b0, "ptr ack");
        i_lmp_master_model.start_cond();
        send(AR, 1'b0, "read addr ack");
        recv(8'h03, 1'b0, "reg 09");
        recv(8'h11, 1'b0, "reg 0a");
        recv(8'h33, 1'b0, "reg 0b");
        recv(8'h33, 1'b1, "reg 0b again");
        i_lmp_master_model.stop_cond();
        i_lmp_master_model.start_cond();
        send(AR, 1'b0, "read addr ack");
        recv(DEV_ID, 1'b0, "reg 00");
        recv(8'h00, 1'b1, "reg 01");
        i_lmp_master_model.stop_cond();
        check8("ch4 level", 8'h03, {3'h0, lamp_level[3]});
        // Code 001 is 625 tenths, about 620 clk at one clk per tenth
        wr(8'h04, '{8'h3f});
        check1("ch1 busy", 1'b1, ramp_busy[0]);
        n = 0;
        while (ramp_busy[0] !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        check1("ramp span", 1'b1, n >= 500 && n <= 700);
        check8("ch1 level", 8'h1f, {3'h0, lamp_level[0]});
        for (int s = 0; s < 4; s++) begin
            wr(8'h05, '{8'(s << 4)});
            for (int k = 0; k < 2; k++) begin
                n = 0;
                t = 1'b0;
                while (!t && n < 40) begin
                    aux_pulse(t);
                    n++;
                end
            end
            check8("aux edges per toggle", 8'(8 >> s), 8'(n));
        end
        final_report();
    end
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        final_report();
    end
endmodule // tb_lmp_slave
